// ---- pkg/pin_mux_pkg.sv ----
// Constants for the pin function selection block for pins 30 to 49.
// Assumes a 32-bit AXI4-Lite register bus and one clock domain.
package pin_mux_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int FIELD_W       = 3;   // Bits per pin code
    localparam int PINS_PER_REG  = 10;  // Fields in one register
    localparam int NUM_SEL_REGS  = 2;   // Registers in this block
    localparam int NUM_PINS      = PINS_PER_REG * NUM_SEL_REGS;
    localparam int NUM_ALT       = 6;   // Alternate functions 0 to 5
    localparam int FIRST_PIN     = 30;  // Pin number of field 0
    localparam int DATA_W        = 32;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] ADDR_SEL_30_39 = 12'h000;
    localparam logic [11:0] ADDR_SEL_40_49 = 12'h004;
    localparam logic [31:0] SEL_RESET      = 32'h0000_0000;
    localparam logic [31:0] SEL_WRITE_MASK = 32'h3FFF_FFFF;
    localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

    // ****************************************************************
    // Bus responses
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Function codes held in each field
    // ****************************************************************
    typedef enum logic [2:0] {
        FUNC_INPUT  = 3'b000,
        FUNC_OUTPUT = 3'b001,
        FUNC_ALT5   = 3'b010,
        FUNC_ALT4   = 3'b011,
        FUNC_ALT0   = 3'b100,
        FUNC_ALT1   = 3'b101,
        FUNC_ALT2   = 3'b110,
        FUNC_ALT3   = 3'b111
    } func_code_e;

endpackage : pin_mux_pkg

// ---- pkg/pin_mux_if.sv ----
// Carrier between the register file and the function decoder.
// Assumes pin_mux_pkg is compiled first.
`timescale 1ns/1ps
interface pin_mux_if
    import pin_mux_pkg::*;
#(
    parameter int PINS = NUM_PINS
);
    logic [PINS*FIELD_W-1:0] codes;       // Packed field codes
    logic [PINS-1:0]         is_input;    // Decoded, registered
    logic [PINS-1:0]         is_output;
    logic [PINS*NUM_ALT-1:0] alt_select;  // Six lines per pin

    modport regs (
        output codes,
        input  is_input,
        input  is_output,
        input  alt_select
    );

    modport decoder (
        input  codes,
        output is_input,
        output is_output,
        output alt_select
    );
endinterface : pin_mux_if

// ---- hdl/pin_function_decode.sv ----
// Turns each pin's 3-bit code into registered pad steering lines.
// Assumes codes come straight from the selection registers.
`timescale 1ns/1ps
module pin_function_decode
    import pin_mux_pkg::*;
#(
    parameter int PINS = NUM_PINS
)(
    input  wire logic  clock,
    input  wire logic  rst,
    pin_mux_if.decoder sel
);

    // ****************************************************************
    // Per-pin decode
    // ****************************************************************
    for (genvar g = 0; g < PINS; g++)
    begin : g_pin
        func_code_e code;
        assign code = func_code_e'(sel.codes[g*FIELD_W +: FIELD_W]);

        // Registered so the pad mux never sees a decode glitch
        always_ff @(posedge clock)
        begin
            if (rst)
            begin
                sel.is_input[g]                   <= 1'b1;
                sel.is_output[g]                  <= 1'b0;
                sel.alt_select[g*NUM_ALT +: NUM_ALT] <= 6'h00;
            end
            else
            begin
                sel.is_input[g]  <= (code == FUNC_INPUT);
                sel.is_output[g] <= (code == FUNC_OUTPUT);
                // All eight codes are legal, so no default is needed
                unique case (code)
                    FUNC_ALT0:
                        sel.alt_select[g*NUM_ALT +: NUM_ALT] <= 6'h01;
                    FUNC_ALT1:
                        sel.alt_select[g*NUM_ALT +: NUM_ALT] <= 6'h02;
                    FUNC_ALT2:
                        sel.alt_select[g*NUM_ALT +: NUM_ALT] <= 6'h04;
                    FUNC_ALT3:
                        sel.alt_select[g*NUM_ALT +: NUM_ALT] <= 6'h08;
                    FUNC_ALT4:
                        sel.alt_select[g*NUM_ALT +: NUM_ALT] <= 6'h10;
                    FUNC_ALT5:
                        sel.alt_select[g*NUM_ALT +: NUM_ALT] <= 6'h20;
                    FUNC_INPUT,
                    FUNC_OUTPUT:
                        sel.alt_select[g*NUM_ALT +: NUM_ALT] <= 6'h00;
                endcase
            end
        end
    end

endmodule : pin_function_decode

// ---- hdl/pin_function_select_30_49.sv ----
// Function selection registers for pins 30 to 49, AXI4-Lite slave.
// Assumes a single clock and a synchronous active-high reset; the pad
// ring consumes the decoded per-pin steering outputs.
//
// Notes on behaviour
// - Code 000 input, code 001 output.
// - Codes 100 to 111 give alternates 0-3.
// - Code 011 alternate 4, 010 alternate 5.
// - First register holds pins 30-39, bits 31:30 reserved.
// - Second register holds pins 40-49, same packing.
// - All fields read/write, reset to zero.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module pin_function_select_30_49
    import pin_mux_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    input  wire logic                  clock,
    input  wire logic                  rst,
    // Write address channel
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // Write data channel
    input  wire logic [DATA_W-1:0]     s_axi_wdata,
    input  wire logic [DATA_W/8-1:0]   s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // Write response channel
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // Read address channel
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // Read data channel
    output logic [DATA_W-1:0]          s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Pad steering, one bit or group per pin, pin 30 in bit 0
    output logic [NUM_PINS-1:0]        pin_is_input,
    output logic [NUM_PINS-1:0]        pin_is_output,
    output logic [NUM_PINS*NUM_ALT-1:0] pin_alt_select
);

    // ****************************************************************
    // Storage and carrier
    // ****************************************************************
    logic [DATA_W-1:0] sel_q [NUM_SEL_REGS];

    pin_mux_if #(.PINS(NUM_PINS)) mux_bus ();

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Only full-word aligned matches hit; any other address is refused.
    // Result is {hit, index} so it can feed a continuous assignment.
    function automatic logic [1:0] decode_addr(
        input  logic [ADDR_W-1:0] addr
    );
        logic [11:0] a;
        a = 12'(addr);
        if (ADDR_W > 12 && (addr >> 12) != '0)
            return 2'h0;
        if (a == ADDR_SEL_30_39)
            return 2'h2;
        if (a == ADDR_SEL_40_49)
            return 2'h3;
        return 2'h0;
    endfunction : decode_addr

    // ****************************************************************
    // Write path
    // ****************************************************************
    logic              aw_held_q;
    logic              w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [DATA_W-1:0] w_data_q;
    logic [3:0]        w_strb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              wr_fire;
    logic              wr_hit;
    logic              wr_idx;

    // Address and data are each taken once and held until the write
    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;
    // One write at a time: no fire while a response is still pending
    assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
    assign {wr_hit, wr_idx} = decode_addr(aw_addr_q);

    // Capture write address
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_held_q <= 1'b0;
    end

    // Capture write data and byte strobes
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_held_q <= 1'b0;
    end

    // Selection registers, byte lanes merged under strobe
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            for (int r = 0; r < NUM_SEL_REGS; r++)
                sel_q[r] <= SEL_RESET;
        end
        else if (wr_fire && wr_hit)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (w_strb_q[b])
                    sel_q[wr_idx][b*8 +: 8] <=
                        w_data_q[b*8 +: 8] & SEL_WRITE_MASK[b*8 +: 8];
            end
        end
    end

    // Write response; unmapped writes change nothing and answer SLVERR
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic              rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0]        rresp_q;
    logic              rd_hit;
    logic              rd_idx;

    // A new read is taken only once the last one has been accepted
    assign s_axi_arready = !rvalid_q;
    assign {rd_hit, rd_idx} = decode_addr(s_axi_araddr);

    // Read data is captured at the address handshake
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            // Reserved top bits are never stored, so they read as zero
            rdata_q  <= rd_hit ? (sel_q[rd_idx] & SEL_WRITE_MASK)
                               : UNMAPPED_DATA;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ****************************************************************
    // Field packing
    // ****************************************************************
    // First register carries pins 30-39, second pins 40-49; field k of
    // a register sits in bits 3k+2:3k, so the top two bits are unused
    for (genvar p = 0; p < NUM_PINS; p++)
    begin : g_field
        localparam int REG = p / PINS_PER_REG;
        localparam int FLD = p % PINS_PER_REG;
        assign mux_bus.codes[p*FIELD_W +: FIELD_W] =
            sel_q[REG][FLD*FIELD_W +: FIELD_W];
    end

    // ****************************************************************
    // Decoder and outputs
    // ****************************************************************
    // One decoder for all twenty pins keeps every field decoded alike
    pin_function_decode #(
        .PINS (NUM_PINS)
    ) u_decode (
        .clock (clock),
        .rst   (rst),
        .sel   (mux_bus.decoder)
    );

    assign pin_is_input   = mux_bus.is_input;
    assign pin_is_output  = mux_bus.is_output;
    assign pin_alt_select = mux_bus.alt_select;

endmodule : pin_function_select_30_49

// ---- verif/pin_mux_assertions.sv ----
// Checker for the pin function select block, bound to its top ports.
// Assumes pin_mux_pkg is compiled first and a single clock domain.
`timescale 1ns/1ps
module pin_mux_assertions
    import pin_mux_pkg::*;
(
    input wire logic                        clock,
    input wire logic                        rst,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic [DATA_W-1:0]           s_axi_rdata,
    input wire logic [NUM_PINS-1:0]         pin_is_input,
    input wire logic [NUM_PINS-1:0]         pin_is_output,
    input wire logic [NUM_PINS*NUM_ALT-1:0] pin_alt_select
);
    logic [NUM_PINS-1:0] alt_any;

    // Per pin flag: some alternate line is driven
    always_comb
    begin
        for (int p = 0; p < NUM_PINS; p++)
        begin
            alt_any[p] = |pin_alt_select[NUM_ALT*p +: NUM_ALT];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    io_excl_a: assert property ((pin_is_input & pin_is_output) == '0)
        else $error("pin is input and output at once");
    alt_excl_a: assert property ((alt_any & (pin_is_input | pin_is_output))
        == '0)
        else $error("alternate line beside plain role");
    one_role_a: assert property ((alt_any | pin_is_input | pin_is_output)
        == '1)
        else $error("pin left without a role");
    reset_pins_a: assert property ($past(rst) |-> pin_is_input == '1
        && pin_is_output == '0 && pin_alt_select == '0)
        else $error("pins not inputs after reset");
    rsv_read_a: assert property (s_axi_rvalid |->
        s_axi_rdata[31:30] == 2'b00)
        else $error("reserved bits read nonzero");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid)
        else $error("read not answered next cycle");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
endmodule : pin_mux_assertions

bind pin_function_select_30_49 pin_mux_assertions i_chk (
    .clock          (clock),
    .rst            (rst),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_bready   (s_axi_bready),
    .s_axi_bresp    (s_axi_bresp),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready),
    .s_axi_rdata    (s_axi_rdata),
    .pin_is_input   (pin_is_input),
    .pin_is_output  (pin_is_output),
    .pin_alt_select (pin_alt_select)
);

// ---- verif/tb.sv ----
// Self-checking bench for the pin function select block.
// Assumes the package, interface and design are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
 $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb
    import pin_mux_pkg::*;
;
    logic clock = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, m0 = '0, m1 = '0, w, rdata;
    logic [3:0]  wstrb = '0;
    logic [1:0]  bresp, rresp;
    logic [NUM_PINS-1:0] p_in, p_out, e_in, e_out;
    logic [NUM_PINS*NUM_ALT-1:0] p_alt, e_alt;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [33:0] exp_r;
    logic [1:0]  exp_b;
    int n_errors = 0, checked = 0, cycles = 0;

    always #2 clock = ~clock;

    pin_function_select_30_49 i_dut (
        .clock(clock), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_is_input(p_in), .pin_is_output(p_out), .pin_alt_select(p_alt)
    );

    // Watcher: each accepted answer against the oldest note; hang guard
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        // Note is taken off once, as the macro reads its value twice
        if (rvalid && rready)
        begin
            exp_r = rq.pop_front();
            `CHK({rresp, rdata}, exp_r)
        end
        if (bvalid && bready)
        begin
            exp_b = bq.pop_front();
            `CHK(bresp, exp_b)
        end
        if (cycles > 20000)
        begin
            n_errors++;
            end_sim();
        end
    end

    // One write; reserved bits and unselected lanes never reach the model
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        bq.push_back((a == ADDR_SEL_30_39 || a == ADDR_SEL_40_49) ?
                     RESP_OKAY : RESP_SLVERR);
        for (int b = 0; b < 4; b++)
        begin
            if (s[b] && a == ADDR_SEL_30_39) m0[8*b +: 8] = d[8*b +: 8];
            if (s[b] && a == ADDR_SEL_40_49) m1[8*b +: 8] = d[8*b +: 8];
        end
        m0 &= SEL_WRITE_MASK;
        m1 &= SEL_WRITE_MASK;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        forever
        begin
            @(posedge clock);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1;
        end
        bready <= 0;
    endtask : wr

    // One read; rready comes late so the answer must stand
    task automatic rd(input logic [11:0] a);
        if (a == ADDR_SEL_30_39) rq.push_back({RESP_OKAY, m0});
        else if (a == ADDR_SEL_40_49) rq.push_back({RESP_OKAY, m1});
        else rq.push_back({RESP_SLVERR, UNMAPPED_DATA});
        @(posedge clock);
        araddr <= a;
        arvalid <= 1;
        forever
        begin
            @(posedge clock);
            if (arready) arvalid <= 0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1;
        end
        rready <= 0;
    endtask : rd

    // Expected steering from the model words, pin 30 in field 0
    task automatic pins;
        logic [2:0]  c;
        logic [59:0] f;
        f = {m1[29:0], m0[29:0]};
        for (int p = 0; p < NUM_PINS; p++)
        begin
            c = f[3*p +: 3];
            e_in[p] = (c == FUNC_INPUT);
            e_out[p] = (c == FUNC_OUTPUT);
            e_alt[6*p +: 6] = c[2] ? 6'h01 << c[1:0] : 6'h00;
            if (c == FUNC_ALT4) e_alt[6*p +: 6] = 6'h10;
            if (c == FUNC_ALT5) e_alt[6*p +: 6] = 6'h20;
        end
        @(posedge clock);
        `CHK(p_in, e_in)
        `CHK(p_out, e_out)
        `CHK(p_alt, e_alt)
    endtask : pins

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // Main sequence
    initial
    begin
        void'($urandom(32'h24BEF894));
        repeat (8) @(posedge clock);
        rst <= 0;
        rd(ADDR_SEL_30_39);
        rd(ADDR_SEL_40_49);
        pins();
        $display("test reset done");
        // Every code in every field, then random words; top bits set in the pins 30-39 code words
        for (int i = 0; i < 14; i++)
        begin
            w = (i < 8) ? {2'b11, {10{3'(i)}}} : $urandom();
            wr(ADDR_SEL_30_39, w, 4'hF);
            wr(ADDR_SEL_40_49, ~w, 4'hF);
            rd(ADDR_SEL_30_39);
            rd(ADDR_SEL_40_49);
            pins();
        end
        $display("test codes done");
        // Partial byte enables leave other lanes alone
        for (int i = 0; i < 6; i++)
        begin
            wr(i[0] ? ADDR_SEL_40_49 : ADDR_SEL_30_39, $urandom(),
               4'($urandom()));
            rd(i[0] ? ADDR_SEL_40_49 : ADDR_SEL_30_39);
            pins();
        end
        $display("test strobes done");
        // Unmapped and misaligned places refuse and change nothing
        wr(12'h008, '1, 4'hF);
        rd(12'h008);
        wr(12'h002, '1, 4'hF);
        rd(12'hFFC);
        rd(ADDR_SEL_30_39);
        pins();
        $display("test unmapped done");
        // Reset in mid-run puts every field back to input
        rst <= 1;
        repeat (2) @(posedge clock);
        rst <= 0;
        m0 = '0;
        m1 = '0;
        rd(ADDR_SEL_30_39);
        rd(ADDR_SEL_40_49);
        pins();
        $display("test second reset done");
        end_sim();
    end
endmodule : tb
